// *** ntt_params.svh ***
// Constants for the tree test port: strap codes, chain sizes, timing, map
`ifndef NTT_PARAMS_SVH
`define NTT_PARAMS_SVH

// ---------------------------------------------------------------------
// Strap codes
// ---------------------------------------------------------------------
`define NTT_OPSEL_TEST       3'h7
`define NTT_OPSEL_RMII       3'h1
`define NTT_OPSEL_SMII       3'h2
`define NTT_STROBE_TEST      1'h0
`define NTT_NAND_SEL_A       1'h0
`define NTT_NAND_SEL_B       1'h1
`define NTT_XNOR_SEL_A       1'h1
`define NTT_XNOR_SEL_B       1'h0

// ---------------------------------------------------------------------
// Chain sizes and timing
// ---------------------------------------------------------------------
`define NTT_CHAIN1_LEN       52
`define NTT_CHAIN2_LEN       49
`define NTT_TREE_DELAY_NS    20
`define NTT_CLK_PERIOD_NS    8
`define NTT_SETTLE_CYC       ((`NTT_TREE_DELAY_NS / `NTT_CLK_PERIOD_NS) \
                              < 1 ? 1 : \
                              (`NTT_TREE_DELAY_NS / `NTT_CLK_PERIOD_NS))

// ---------------------------------------------------------------------
// Register map (byte addresses) and fields
// ---------------------------------------------------------------------
`define NTT_ADDR_W           12
`define NTT_REG_STATUS       12'h000
`define NTT_REG_CTRL         12'h004
`define NTT_REG_TOGGLES      12'h008
`define NTT_CTRL_RESET       32'h0000_0000
`define NTT_ST_OPSEL_LSB     0
`define NTT_ST_STROBE        3
`define NTT_ST_SEL_A         4
`define NTT_ST_SEL_B         5
`define NTT_ST_NAND          6
`define NTT_ST_XNOR          7
`define NTT_ST_RESERVED      8
`define NTT_ST_VALID         9
`define NTT_ST_CAP1          10
`define NTT_ST_CAP2          11
`define NTT_CTRL_OBSERVE     0
`define NTT_TOG_W            16

`endif

// *** ntt_pkg.sv ***
// Types shared by the tree test port modules
package ntt_pkg;

   typedef enum logic [2:0]
   {
      MODE_UNKNOWN  = 3'b000,
      MODE_RMII     = 3'b001,
      MODE_SMII     = 3'b010,
      MODE_NAND     = 3'b011,
      MODE_XNOR     = 3'b100,
      MODE_RESERVED = 3'b101
   } ntt_mode_t;

   typedef enum logic [1:0]
   {
      ST_FILL0 = 2'b00,
      ST_FILL1 = 2'b01,
      ST_RUN   = 2'b10
   } ntt_strap_state_t;

endpackage

// *** ntt_chain_if.sv ***
// Connection between the port control and one tree chain
interface ntt_chain_if #(parameter int N = 52);
   logic [N-1:0] pads;
   logic         start;
   logic         xnor_sel;
   logic         enable;
   logic         result;

   modport src
   (
      output pads,
      output start,
      output xnor_sel,
      output enable,
      input  result
   );

   modport tree
   (
      input  pads,
      input  start,
      input  xnor_sel,
      input  enable,
      output result
   );
endinterface

// *** ntt_tree_chain.sv ***
// One asynchronous NAND or XNOR cascade over the periphery input buffers
module ntt_tree_chain #(parameter int N = 52)
(
   // Chain connection
   ntt_chain_if.tree bus
);

   logic [N:0] stage;

   // ------------------------------------------------------------------
   // Stage function
   // ------------------------------------------------------------------
   function automatic logic tree_cell(input logic prev,
                                      input logic pad,
                                      input logic xnor_sel);
      tree_cell = xnor_sel ? ~(prev ^ pad) : ~(prev & pad);
   endfunction

   // ------------------------------------------------------------------
   // Cascade, position one farthest from the output
   // ------------------------------------------------------------------
   assign stage[0] = bus.start;

   for (genvar i = 0; i < N; i++)
   begin : g_stage
      // Each stage folds in exactly one pad
      assign stage[i+1] = tree_cell(stage[i], bus.pads[i],
                                    bus.xnor_sel);
   end

   // No clock on this path; idle low when no tree test is latched
   assign bus.result = bus.enable ? stage[N] : 1'b0;

endmodule

// *** ntt_test_port.sv ***
// Test port control: strap latch, tree chains, pad tri-state, APB status
//
// Contract
// - Operating-select 111 selects manufacturing test, not a system mode.
// - Select 111, strobe 0, A 0, B 1 at reset gives NAND tree.
// - Select 111, strobe 0, A 1, B 0 at reset gives XNOR tree.
// - Chain input toggle reaches chain output in about 20 ns.
// - In tree test all pads tri-state except straps and chain outputs.
// - Tree test cascades input buffers through NAND or XNOR gates.
// - Two independent chains, each with own input and output pin.
// - Position one farthest from output; chains of 52 and 49.
// - Tree outputs follow inputs combinationally, no clock involved.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "ntt_params.svh"

module ntt_test_port #(
   parameter int C1_LEN = `NTT_CHAIN1_LEN,
   parameter int C2_LEN = `NTT_CHAIN2_LEN
)
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`NTT_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Strap pins
   input  wire logic [2:0]             op_select_pin,
   input  wire logic                   test_strobe_pin,
   input  wire logic                   tree_select_a,
   input  wire logic                   tree_select_b,
   // Chain input pins and their normal-mode drive enables
   input  wire logic                   chain_one_input_pin,
   input  wire logic                   chain_two_input_pin,
   input  wire logic [1:0]             core_input_pin_oe,
   output logic      [1:0]             input_pin_oe,
   // Periphery input buffers and pad enables
   input  wire logic [C1_LEN-1:0]      chain_one_pad_in,
   input  wire logic [C2_LEN-1:0]      chain_two_pad_in,
   input  wire logic [C1_LEN-1:0]      core_chain_one_oe,
   input  wire logic [C2_LEN-1:0]      core_chain_two_oe,
   output logic      [C1_LEN-1:0]      chain_one_pad_oe,
   output logic      [C2_LEN-1:0]      chain_two_pad_oe,
   // Chain output pins
   input  wire logic                   core_irq_n,
   input  wire logic                   core_irq_oe,
   output logic                        chain_one_output_pin,
   output logic                        chain_one_output_oe,
   output logic                        chain_two_output_pin,
   output logic                        chain_two_output_oe,
   // Status
   output logic                        test_mode_active
);

   localparam int SETTLE = `NTT_SETTLE_CYC;

   // ------------------------------------------------------------------
   // Strap decode
   // ------------------------------------------------------------------
   function automatic ntt_pkg::ntt_mode_t decode_mode(
      input logic [2:0] opsel,
      input logic       strobe,
      input logic       sel_a,
      input logic       sel_b);
      ntt_pkg::ntt_mode_t m;
      m = ntt_pkg::MODE_RESERVED;
      if (opsel == `NTT_OPSEL_RMII)
         m = ntt_pkg::MODE_RMII;
      else if (opsel == `NTT_OPSEL_SMII)
         m = ntt_pkg::MODE_SMII;
      else if (opsel == `NTT_OPSEL_TEST && strobe == `NTT_STROBE_TEST)
      begin
         if (sel_a == `NTT_NAND_SEL_A && sel_b == `NTT_NAND_SEL_B)
            m = ntt_pkg::MODE_NAND;
         else if (sel_a == `NTT_XNOR_SEL_A && sel_b == `NTT_XNOR_SEL_B)
            m = ntt_pkg::MODE_XNOR;
      end
      // Anything else is reserved and never enters a tree test
      decode_mode = m;
   endfunction

   // ------------------------------------------------------------------
   // Strap synchronisers and latch at reset release
   // ------------------------------------------------------------------
   logic [5:0]                 strap_s1_r;
   logic [5:0]                 strap_s2_r;
   logic [5:0]                 strap_r;
   ntt_pkg::ntt_mode_t         mode_r;
   ntt_pkg::ntt_strap_state_t  sstate_r;
   ntt_pkg::ntt_strap_state_t  sstate_nxt;
   logic                       tree_on;
   logic                       xnor_on;
   logic                       taken_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_s1_r <= 6'h00;
         strap_s2_r <= 6'h00;
      end
      else
      begin
         strap_s1_r <= {tree_select_b, tree_select_a, test_strobe_pin,
                        op_select_pin};
         strap_s2_r <= strap_s1_r;
      end
   end

   always_comb
   begin
      case (sstate_r)
         ntt_pkg::ST_FILL0: sstate_nxt = ntt_pkg::ST_FILL1;
         ntt_pkg::ST_FILL1: sstate_nxt = ntt_pkg::ST_RUN;
         ntt_pkg::ST_RUN:   sstate_nxt = ntt_pkg::ST_RUN;
         default:           sstate_nxt = ntt_pkg::ST_FILL0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sstate_r <= ntt_pkg::ST_FILL0;
      else
         sstate_r <= sstate_nxt;
   end

   // Straps are taken once, after both synchroniser stages hold pin values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_r <= 6'h00;
         mode_r  <= ntt_pkg::MODE_UNKNOWN;
         taken_r <= 1'b0;
      end
      else if (sstate_r == ntt_pkg::ST_RUN && !taken_r)
      begin
         strap_r <= strap_s2_r;
         mode_r  <= decode_mode(strap_s2_r[2:0], strap_s2_r[3],
                                strap_s2_r[4], strap_s2_r[5]);
         taken_r <= 1'b1;
      end
   end

   assign tree_on = (mode_r == ntt_pkg::MODE_NAND) ||
                    (mode_r == ntt_pkg::MODE_XNOR);
   assign xnor_on = (mode_r == ntt_pkg::MODE_XNOR);
   assign test_mode_active = tree_on;

   // ------------------------------------------------------------------
   // Tree chains
   // ------------------------------------------------------------------
   ntt_chain_if #(.N(C1_LEN)) c1_bus ();
   ntt_chain_if #(.N(C2_LEN)) c2_bus ();

   // Two separate cascades, pad index 0 is chain position one
   assign c1_bus.pads     = chain_one_pad_in;
   assign c1_bus.start    = chain_one_input_pin;
   assign c1_bus.xnor_sel = xnor_on;
   assign c1_bus.enable   = tree_on;
   assign c2_bus.pads     = chain_two_pad_in;
   assign c2_bus.start    = chain_two_input_pin;
   assign c2_bus.xnor_sel = xnor_on;
   assign c2_bus.enable   = tree_on;

   ntt_tree_chain #(.N(C1_LEN)) u_chain_one
   (
      .bus (c1_bus.tree)
   );

   ntt_tree_chain #(.N(C2_LEN)) u_chain_two
   (
      .bus (c2_bus.tree)
   );

   // ------------------------------------------------------------------
   // Pad control
   // ------------------------------------------------------------------
   // Combinational on purpose: a register would add clock dependence
   assign chain_one_pad_oe = tree_on ? '0 : core_chain_one_oe;
   assign chain_two_pad_oe = tree_on ? '0 : core_chain_two_oe;
   assign input_pin_oe     = tree_on ? 2'h0 : core_input_pin_oe;

   assign chain_one_output_pin = tree_on ? c1_bus.result
                                         : core_irq_n;
   assign chain_one_output_oe  = tree_on | core_irq_oe;
   assign chain_two_output_pin = c2_bus.result;
   assign chain_two_output_oe  = tree_on;

   // ------------------------------------------------------------------
   // Observation of chain activity
   // ------------------------------------------------------------------
   logic [3:0]            obs_s1_r;
   logic [3:0]            obs_s2_r;
   logic [1:0]            in_last_r;
   logic [1:0]            cap_r;
   logic [7:0]            settle_r;
   logic                  observe_r;
   logic [`NTT_TOG_W-1:0] toggles_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         obs_s1_r <= 4'h0;
         obs_s2_r <= 4'h0;
      end
      else
      begin
         obs_s1_r <= {chain_two_input_pin, chain_one_input_pin,
                      c2_bus.result, c1_bus.result};
         obs_s2_r <= obs_s1_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_last_r <= 2'h0;
      else
         in_last_r <= obs_s2_r[3:2];
   end

   // Wait out the tree delay after an input edge before capturing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         settle_r <= 8'h00;
      else if (observe_r && (obs_s2_r[3:2] != in_last_r))
         settle_r <= 8'(SETTLE);
      else if (settle_r != 8'h00)
         settle_r <= settle_r - 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cap_r <= 2'h0;
      else if (observe_r && settle_r == 8'h01)
         cap_r <= obs_s2_r[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         toggles_r <= '0;
      else if (observe_r && settle_r == 8'h01 && obs_s2_r[1:0] != cap_r)
         toggles_r <= toggles_r + `NTT_TOG_W'(1);
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic        setup;
   logic        wr_acc;
   logic        hit;
   logic [31:0] status;

   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign hit    = (paddr == `NTT_REG_STATUS) ||
                   (paddr == `NTT_REG_CTRL)   ||
                   (paddr == `NTT_REG_TOGGLES);
   // Zero wait states; errors only on unmapped addresses
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   always_comb
   begin
      status = 32'h0000_0000;
      status[`NTT_ST_OPSEL_LSB +: 3] = strap_r[2:0];
      status[`NTT_ST_STROBE]   = strap_r[3];
      status[`NTT_ST_SEL_A]    = strap_r[4];
      status[`NTT_ST_SEL_B]    = strap_r[5];
      status[`NTT_ST_NAND]     = (mode_r == ntt_pkg::MODE_NAND);
      status[`NTT_ST_XNOR]     = (mode_r == ntt_pkg::MODE_XNOR);
      status[`NTT_ST_RESERVED] = (mode_r == ntt_pkg::MODE_RESERVED);
      status[`NTT_ST_VALID]    = taken_r;
      status[`NTT_ST_CAP1]     = cap_r[0];
      status[`NTT_ST_CAP2]     = cap_r[1];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         observe_r <= 1'(`NTT_CTRL_RESET);
      else if (wr_acc && paddr == `NTT_REG_CTRL)
         observe_r <= pwdata[`NTT_CTRL_OBSERVE];
   end

   // Read data is loaded in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup && !pwrite)
      begin
         case (paddr)
            `NTT_REG_STATUS:  prdata <= status;
            `NTT_REG_CTRL:    prdata <= {31'h0000_0000, observe_r};
            `NTT_REG_TOGGLES: prdata <= 32'(toggles_r);
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// *** ntt_test_port_monitor.sv ***
// Checker on the tree test port pins
module ntt_test_port_monitor #(
   parameter int C1_LEN = 52,
   parameter int C2_LEN = 49
)
(
   // Clock, reset and straps
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic [2:0]        op_select_pin,
   input wire logic              test_strobe_pin,
   input wire logic              tree_select_a,
   input wire logic              tree_select_b,
   // Chain inputs
   input wire logic              chain_one_input_pin,
   input wire logic              chain_two_input_pin,
   input wire logic [C1_LEN-1:0] chain_one_pad_in,
   input wire logic [C2_LEN-1:0] chain_two_pad_in,
   // Enables and chain outputs
   input wire logic [1:0]        input_pin_oe,
   input wire logic [C1_LEN-1:0] core_chain_one_oe,
   input wire logic [C2_LEN-1:0] core_chain_two_oe,
   input wire logic [C1_LEN-1:0] chain_one_pad_oe,
   input wire logic [C2_LEN-1:0] chain_two_pad_oe,
   input wire logic              core_irq_n,
   input wire logic              core_irq_oe,
   input wire logic              chain_one_output_pin,
   input wire logic              chain_one_output_oe,
   input wire logic              chain_two_output_pin,
   input wire logic              chain_two_output_oe,
   input wire logic              test_mode_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic xnor_r;
   logic tm;
   assign tm = test_mode_active;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Tree kind follows select A until a tree mode latches, then holds
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xnor_r <= 1'h0;
      else if (!tm)
         xnor_r <= tree_select_a;
   end

   property p_code;
      $rose(tm) |-> $past(op_select_pin) == 3'h7 && !$past(test_strobe_pin)
         && $past(tree_select_a) != $past(tree_select_b);
   endproperty
   a_code: assert property (p_code)
      else $error("tree mode latched from a non-test strap code");
   property p_hiz;
      tm |-> chain_one_pad_oe == '0 && chain_two_pad_oe == '0
         && input_pin_oe == 2'h0;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("pad enable left on in tree test");
   property p_outs;
      tm |-> chain_one_output_oe && chain_two_output_oe;
   endproperty
   a_outs: assert property (p_outs)
      else $error("chain output not driven in tree test");
   property p_npads;
      !tm |-> chain_one_pad_oe == core_chain_one_oe
         && chain_two_pad_oe == core_chain_two_oe;
   endproperty
   a_npads: assert property (p_npads)
      else $error("pad enables disturbed outside tree test");
   property p_nouts;
      !tm |-> chain_one_output_pin == core_irq_n
         && chain_one_output_oe == core_irq_oe && !chain_two_output_oe;
   endproperty
   a_nouts: assert property (p_nouts)
      else $error("output pins disturbed outside tree test");
   property p_nand1;
      tm && !xnor_r && &chain_one_pad_in |-> chain_one_output_pin
         == (chain_one_input_pin ^ (C1_LEN % 2 == 1));
   endproperty
   a_nand1: assert property (p_nand1)
      else $error("chain one NAND pass path wrong");
   property p_nand2;
      tm && !xnor_r && &chain_two_pad_in |-> chain_two_output_pin
         == (chain_two_input_pin ^ (C2_LEN % 2 == 1));
   endproperty
   a_nand2: assert property (p_nand2)
      else $error("chain two NAND pass path wrong");
   property p_last;
      tm && !xnor_r && !chain_one_pad_in[C1_LEN-1] |-> chain_one_output_pin;
   endproperty
   a_last: assert property (p_last)
      else $error("last chain position not next to the output");
   property p_xpar;
      tm && xnor_r |-> chain_two_output_pin == (chain_two_input_pin
         ^ (^chain_two_pad_in) ^ (C2_LEN % 2 == 1));
   endproperty
   a_xpar: assert property (p_xpar)
      else $error("chain two XNOR parity wrong");
endmodule

bind ntt_test_port ntt_test_port_monitor #(
   .C1_LEN(C1_LEN),
   .C2_LEN(C2_LEN)
) mon_u (.*);

// *** ntt_tester_model.sv ***
// Manufacturing tester: holds straps and drives the chain pins
module ntt_tester_model #(
   parameter int C1_LEN = 52,
   parameter int C2_LEN = 49
)
(
   // Clock
   input wire logic          pclk,
   // Strap pins
   output logic [2:0]        op_select_pin,
   output logic              test_strobe_pin,
   output logic              tree_select_a,
   output logic              tree_select_b,
   // Chain stimulus
   output logic              chain_one_input_pin,
   output logic              chain_two_input_pin,
   output logic [C1_LEN-1:0] chain_one_pad_in,
   output logic [C2_LEN-1:0] chain_two_pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {op_select_pin, test_strobe_pin, tree_select_a, tree_select_b} = 6'h08;
      chain_one_input_pin = 1'b0;
      chain_two_input_pin = 1'b0;
      chain_one_pad_in = '1;
      chain_two_pad_in = '1;
   end

   // Straps must stay put across reset; only the bench changes them
   task automatic set_straps(input logic [5:0] s);
      @(posedge pclk);
      {op_select_pin, test_strobe_pin, tree_select_a, tree_select_b} <= s;
   endtask

   task automatic drive(input logic i1, input logic i2,
                        input logic [C1_LEN-1:0] p1,
                        input logic [C2_LEN-1:0] p2);
      @(posedge pclk);
      chain_one_input_pin <= i1;
      chain_two_input_pin <= i2;
      chain_one_pad_in <= p1;
      chain_two_pad_in <= p2;
   endtask
endmodule

// *** ntt_test_port_tb.sv ***
// Self-checking bench for the tree test port
`include "ntt_params.svh"
module ntt_test_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N1 = `NTT_CHAIN1_LEN;
   localparam int N2 = `NTT_CHAIN2_LEN;
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]     paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [2:0]      op_select_pin;
   logic            test_strobe_pin, tree_select_a, tree_select_b, err;
   logic            chain_one_input_pin, chain_two_input_pin, test_mode_active;
   logic [1:0]      core_input_pin_oe, input_pin_oe;
   logic [N1-1:0]   chain_one_pad_in, core_chain_one_oe, chain_one_pad_oe;
   logic [N2-1:0]   chain_two_pad_in, core_chain_two_oe, chain_two_pad_oe;
   logic            core_irq_n, core_irq_oe, chain_one_output_pin;
   logic            chain_one_output_oe, chain_two_output_pin;
   logic            chain_two_output_oe;
   int              n_fail = 0;
   int              n_compared = 0;

   ntt_tester_model tester_u (.*);
   ntt_test_port dut_u (.*);

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic boot(input logic [5:0] s);
      tester_u.set_straps(s);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask

   function automatic logic ref_out(input logic i, input logic [63:0] p,
                                    input int n, input logic x);
      logic v;
      v = i;
      for (int k = 0; k < n; k++)
         v = x ? ~(v ^ p[k]) : ~(v & p[k]);
      return v;
   endfunction

   task automatic t_normal();
      boot(6'h08);
      core_chain_one_oe <= {13{4'ha}};
      core_chain_two_oe <= {N2{1'b1}};
      core_irq_n <= 1'b0;
      core_irq_oe <= 1'b1;
      core_input_pin_oe <= 2'h2;
      @(negedge pclk);
      chk(chain_one_pad_oe, {13{4'ha}});
      chk({input_pin_oe, chain_two_output_oe, chain_one_output_pin}, 4'h8);
      chk(test_mode_active, 1'b0);
      apb(0, `NTT_REG_STATUS, 32'h0);
      chk(rd[9:0], 10'h201);
      apb(1, `NTT_REG_CTRL, 32'h1);
      apb(0, `NTT_REG_CTRL, 32'h0);
      chk({err, rd}, {1'b0, 32'h1});
      apb(0, 12'h00c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
   endtask

   task automatic t_reserved();
      boot(6'h3d);
      @(negedge pclk);
      chk({test_mode_active, chain_two_output_oe, chain_two_output_pin},
          3'h0);
      chk(chain_two_pad_oe, {N2{1'b1}});
      apb(0, `NTT_REG_STATUS, 32'h0);
      chk(rd[9:0], 10'h32f);
   endtask

   task automatic t_tree(input logic x);
      logic [63:0] pd;
      for (int k = -1; k < N1; k++)
         for (int i = 0; i < 2; i++)
         begin
            pd = '1;
            if (k >= 0)
               pd[k] = 1'b0;
            tester_u.drive(i[0], !i[0], pd[N1-1:0], pd[N2-1:0]);
            @(negedge pclk);
            chk(chain_one_output_pin, ref_out(i[0], pd, N1, x));
            chk(chain_two_output_pin, ref_out(!i[0], pd, N2, x));
            chk(|{chain_one_pad_oe, chain_two_pad_oe, input_pin_oe}, 1'b0);
            chk({chain_one_output_oe, chain_two_output_oe}, 2'h3);
         end
   endtask

   task automatic t_mode(input logic [5:0] s, input logic x,
                         input logic [11:0] st);
      // Park the chain inputs low so the observed edge below is a fresh one
      tester_u.drive(1'b0, 1'b0, '1, '1);
      boot(s);
      chk(test_mode_active, 1'b1);
      apb(0, `NTT_REG_CTRL, 32'h0);
      chk(rd, `NTT_CTRL_RESET);
      apb(1, `NTT_REG_CTRL, 32'h1);
      tester_u.drive(1'b1, 1'b0, '1, '1);
      repeat (10) @(posedge pclk);
      apb(0, `NTT_REG_TOGGLES, 32'h0);
      chk(rd, 32'h1);
      apb(0, `NTT_REG_STATUS, 32'h0);
      chk(rd[11:0], st);
      t_tree(x);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      core_input_pin_oe = 2'h0;
      core_chain_one_oe = '0;
      core_chain_two_oe = '0;
      core_irq_n = 1'b1;
      core_irq_oe = 1'b0;
      t_normal();
      t_mode(6'h39, 1'b0, 12'he67);
      t_mode(6'h3a, 1'b1, 12'h697);
      t_reserved();
      print_verdict();
   end

   // Cut a hang well past the expected run length
   initial
   begin
      #100us;
      n_fail++;
      print_verdict();
   end
endmodule
